// [dv/fim_ic_model.sv]
// Interconnect model that accepts message writes after a set stall and records them.
`timescale 1ns/1ns
module fim_ic_model (
  // Clock
  input wire logic pclk,
  // Message write port
  input wire logic msg_valid,
  input wire logic [55:0] msg_addr,
  input wire logic [31:0] msg_data,
  input wire logic [6:0] msg_attr,
  output logic msg_ready,
  output logic msg_err,
  // Bench controls and record
  input wire logic [3:0] stall,
  input wire logic err_req,
  output logic [94:0] got,
  output int n_got
);
  logic [3:0] wait_reg = 4'h0;
  int count = 0;
  assign n_got = count;
  assign msg_ready = msg_valid && wait_reg >= stall;
  assign msg_err = msg_ready && err_req;
  always @(posedge pclk) begin
    wait_reg <= msg_valid && !msg_ready ? wait_reg + 4'h1 : 4'h0;
    if (msg_ready) begin
      got <= {msg_attr, msg_addr, msg_data};
      count <= count + 1;
    end
  end
endmodule

// [dv/fim_top_sva.sv]
// Checker for the fault interrupt message block ports.
`timescale 1ns/1ns
module fim_top_sva #(
  parameter int PA_WIDTH = 48
) (
  // Watched ports
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_event,
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic [55:0] msg_addr,
  input wire logic [31:0] msg_data,
  input wire logic [1:0] msg_sh,
  input wire logic [3:0] msg_mt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  a_zero_wait: assert property (acc |-> pready) else $error("pready low");
  a_map_ok: assert property (acc && paddr[11:4] == 8'he8 |-> !pslverr) else $error("mapped error");
  a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr) && $stable(msg_data))
    else $error("stalled message changed");
  a_msg_once: assert property (msg_valid && msg_ready |=> !msg_valid) else $error("message repeated");
  a_msg_cause: assert property ($rose(msg_valid) |-> $past(fault_event)) else $error("no event");
  a_addr_low: assert property (msg_valid |-> msg_addr[1:0] == 2'h0) else $error("low bits set");
  a_addr_width: assert property (msg_valid |-> (msg_addr >> PA_WIDTH) == '0) else $error("wide address");
  a_sh_outer: assert property (msg_valid && (msg_mt <= 4'h3 || msg_mt == 4'h5) |-> msg_sh == 2'h2)
    else $error("not outer");
  c_stall: cover property (msg_valid && !msg_ready);
  c_done: cover property (msg_valid && msg_ready);
  c_bad: cover property (acc && pslverr);
endmodule
bind fim_top fim_top_sva #(.PA_WIDTH(PA_WIDTH)) u_sva (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .fault_event, .msg_valid, .msg_ready, .msg_addr, .msg_data, .msg_sh, .msg_mt);

// [dv/fim_top_tb.sv]
// Self-checking bench for the fault interrupt message block.
`timescale 1ns/1ns
module fim_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault_event = 0, err_req = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, msg_valid, msg_ready, msg_ns, msg_err, irq;
  logic [55:0] msg_addr;
  logic [31:0] msg_data;
  logic [1:0] msg_sh;
  logic [3:0] msg_mt, stall = 4'h0;
  logic [94:0] got;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] rdf, rdo, f_prdata, o_prdata, f_data;
  logic f_valid, f_ns;
  logic [1:0] f_sh;
  logic [3:0] f_mt;
  logic [55:0] f_addr;
  logic [3:0] mts [6] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'hb, 4'hf};
  logic [1:0] shs [6] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h2, 2'h3};
  int n_got, mismatches = 0, n_compared = 0;
  always #4 pclk = ~pclk;
  fim_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .fault_event, .msg_valid, .msg_ready, .msg_addr, .msg_data, .msg_ns, .msg_sh, .msg_mt, .msg_err, .irq);
  // Second copy with fixed attributes and no disable; it accepts its own writes at once.
  fim_top #(.ENABLE_CONFIGURABLE(1'b0), .NS_WRITES_ALLOWED(1'b1), .SH_CONFIGURABLE(1'b0), .MT_CONFIGURABLE(1'b0))
    dut_fix (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(f_prdata), .pready(),
    .pslverr(), .fault_event, .msg_valid(f_valid), .msg_ready(f_valid), .msg_addr(f_addr), .msg_data(f_data),
    .msg_ns(f_ns), .msg_sh(f_sh), .msg_mt(f_mt), .msg_err(1'b0), .irq());
  // Third copy without interrupt configuration registers.
  fim_top #(.IRQ_CFG_PRESENT(1'b0)) dut_off (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata(o_prdata), .pready(), .pslverr(), .fault_event, .msg_valid(), .msg_ready(1'b0), .msg_addr(),
    .msg_data(), .msg_ns(), .msg_sh(), .msg_mt(), .msg_err(1'b0), .irq());
  fim_ic_model ic (.pclk, .msg_valid, .msg_addr, .msg_data, .msg_attr({msg_ns, msg_sh, msg_mt}), .msg_ready,
    .msg_err, .stall, .err_req, .got, .n_got);
  task automatic chk(input string n, input logic [94:0] s, input logic [94:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("wait states", n, 1);
    rdv = prdata;
    rdf = f_prdata;
    rdo = o_prdata;
    chk("pslverr", pslverr, a[11:4] != 8'he8 && a[11:4] != 8'hef);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, rdv & m, e);
  endtask
  task automatic fire(input int cnt);
    int n0, k;
    n0 = n_got;
    k = 0;
    fault_event <= 1'b1;
    repeat (cnt) @(posedge pclk);
    fault_event <= 1'b0;
    while (n_got == n0 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    repeat (2) @(posedge pclk);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'he8c, 32'hc0, 32'h40, "ctl reset");
    rd(12'hef4, 32'h7, 32'h0, "mask reset");
    apb(1'b1, 12'he80, 32'hffffffff);
    apb(1'b1, 12'he84, 32'hffffffff);
    apb(1'b1, 12'he88, 32'ha5c30f1e);
    apb(1'b1, 12'he8c, 32'hffffffff);
    rd(12'he80, 32'hffffffff, 32'hfffffffc, "addr lo");
    rd(12'he84, 32'hffffffff, 32'h0000ffff, "addr hi");
    rd(12'he88, 32'hffffffff, 32'ha5c30f1e, "payload");
    chk("absent payload", rdo, 32'h0);
    pstrb <= 4'h5;
    apb(1'b1, 12'he88, 32'h11223344);
    pstrb <= 4'hf;
    rd(12'he88, 32'hffffffff, 32'ha5220f44, "strobed payload");
    rd(12'he8c, 32'hffffffff, 32'h000000ff, "control");
    chk("fixed control", rdf, 32'h0);
    apb(1'b1, 12'he90, 32'h1);
    rd(12'he90, 32'hffffffff, 32'h0, "unmapped");
    $display("register test done");
    apb(1'b1, 12'he84, 32'h4321);
    apb(1'b1, 12'he80, 32'h89abcdef);
    apb(1'b1, 12'he8c, 32'h0);
    apb(1'b1, 12'hef4, 32'h0);
    fire(1);
    chk("writes while off", n_got, 0);
    chk("always on", f_data, 32'ha5220f44);
    chk("irq masked", irq, 1'b0);
    rd(12'hef0, 32'h7, 32'h2, "drop status");
    apb(1'b1, 12'hef4, 32'h7);
    chk("irq set", irq, 1'b1);
    apb(1'b1, 12'hef0, 32'h7);
    chk("irq clear", irq, 1'b0);
    $display("disabled test done");
    for (int i = 0; i < 6; i++) begin
      stall <= 4'(i);
      apb(1'b1, 12'he8c, {24'h0, 1'b1, 1'(i), shs[i], mts[i]});
      apb(1'b1, 12'he88, 32'h1000 + i);
      fire(1);
      chk("msg", got, {1'(i), (mts[i] <= 4'h3 || mts[i] == 4'h5) ? 2'h2 : shs[i], mts[i], 56'h432189abcdec,
        32'h1000 + i});
    end
    chk("sent count", n_got, 6);
    chk("fixed attr", {f_ns, f_sh, f_mt, f_addr, f_data}, {7'h60, 56'h432189abcdec, 32'h1005});
    $display("attribute test done");
    apb(1'b1, 12'hef0, 32'h7);
    err_req <= 1'b1;
    fire(1);
    err_req <= 1'b0;
    rd(12'hef0, 32'h7, 32'h5, "error status");
    stall <= 4'h6;
    apb(1'b1, 12'hef0, 32'h7);
    fire(2);
    chk("busy count", n_got, 8);
    rd(12'hef0, 32'h7, 32'h3, "busy status");
    $display("error and busy test done");
    results();
  end
endmodule

// [rtl/fim_cfg_if.sv]
// Configuration bundle passed from the register file to the message writer.
`timescale 1ns/1ns
interface fim_cfg_if #(parameter int AW = 56);
  logic enable;
  logic [AW-1:0] target;
  logic [31:0] payload;
  fim_pkg::fim_attr_s attr;
  modport src (output enable, output target, output payload, output attr);
  modport dst (input enable, input target, input payload, input attr);
endinterface

// [rtl/fim_map.svh]
// Register offsets, field positions, reset values and attribute codes of the fault interrupt message block.
`ifndef FIM_MAP_SVH
`define FIM_MAP_SVH
`define FIM_OFS_TARGET_LO 12'he80
`define FIM_OFS_TARGET_HI 12'he84
`define FIM_OFS_PAYLOAD 12'he88
`define FIM_OFS_CONTROL 12'he8c
`define FIM_OFS_IRQ_STATUS 12'hef0
`define FIM_OFS_IRQ_MASK 12'hef4
`define FIM_ADDR_LSB 2
`define FIM_ADDR_MSB 55
`define FIM_CTL_ENABLE_BIT 7
`define FIM_CTL_NS_BIT 6
`define FIM_CTL_SH_MSB 5
`define FIM_CTL_SH_LSB 4
`define FIM_CTL_MT_MSB 3
`define FIM_CTL_MT_LSB 0
`define FIM_CTL_ENABLE_RST 1'h0
`define FIM_SH_NONE 2'h0
`define FIM_SH_OUTER 2'h2
`define FIM_SH_INNER 2'h3
`define FIM_MT_NORMAL_NC 4'h5
`define FIM_MT_DEVICE_MAX 4'h3
`define FIM_MT_RSVD_A 4'h4
`define FIM_MT_RSVD_B 4'h8
`define FIM_MT_RSVD_C 4'hc
`define FIM_STS_SENT_BIT 0
`define FIM_STS_DROP_BIT 1
`define FIM_STS_ERR_BIT 2
`endif

// [rtl/fim_pkg.sv]
// Types shared by the fault interrupt message block.
package fim_pkg;
  typedef enum logic [1:0] {
    FIM_IDLE,
    FIM_SEND
  } fim_state_e;
  typedef struct packed {
    logic ns;
    logic [1:0] sh;
    logic [3:0] mt;
  } fim_attr_s;
endpackage

// [rtl/fim_sender.sv]
// Issues one message write per fault event that arrives while enabled and idle, using the configured address, payload, ns and mt;
// sh is the configured value except for device and normal non-cacheable memory types, which are sent as outer shareable.
`timescale 1ns/1ns
`include "fim_map.svh"
module fim_sender #(
  parameter int AW = 56
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  fim_cfg_if.dst cfg,
  // Fault event
  input wire logic fault_event,
  // Message write port
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [AW-1:0] msg_addr,
  output logic [31:0] msg_data,
  output logic msg_ns,
  output logic [1:0] msg_sh,
  output logic [3:0] msg_mt,
  input wire logic msg_err,
  // Event pulses
  output logic sent_pulse,
  output logic drop_pulse,
  output logic err_pulse
);
  fim_pkg::fim_state_e state_reg, state_next;
  logic mt_forces_outer;
  logic [1:0] sh_eff;
  logic launch;
  logic done;
  assign mt_forces_outer = (cfg.attr.mt <= `FIM_MT_DEVICE_MAX) || (cfg.attr.mt == `FIM_MT_NORMAL_NC);
  assign sh_eff = mt_forces_outer ? `FIM_SH_OUTER : cfg.attr.sh;
  assign launch = fault_event && cfg.enable && (state_reg == fim_pkg::FIM_IDLE);
  assign done = (state_reg == fim_pkg::FIM_SEND) && msg_ready;
  assign msg_valid = (state_reg == fim_pkg::FIM_SEND);
  assign drop_pulse = fault_event && !launch;
  assign sent_pulse = done;
  assign err_pulse = done && msg_err;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fim_pkg::FIM_IDLE: begin
        if (launch) begin
          state_next = fim_pkg::FIM_SEND;
        end
      end
      fim_pkg::FIM_SEND: begin
        if (msg_ready) begin
          state_next = fim_pkg::FIM_IDLE;
        end
      end
      default: begin
        state_next = fim_pkg::FIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fim_pkg::FIM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Attributes are frozen at launch so a register write cannot tear a write in flight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_addr <= '0;
      msg_data <= 32'h0;
      msg_ns <= 1'h0;
      msg_sh <= 2'h0;
      msg_mt <= 4'h0;
    end else if (launch) begin
      msg_addr <= cfg.target;
      msg_data <= cfg.payload;
      msg_ns <= cfg.attr.ns;
      msg_sh <= sh_eff;
      msg_mt <= cfg.attr.mt;
    end
  end
endmodule

// [rtl/fim_top.sv]
// Fault interrupt message configuration registers with APB access and the message writer.
`timescale 1ns/1ns
`include "fim_map.svh"
module fim_top #(
  parameter bit IRQ_CFG_PRESENT = 1'b1,
  parameter bit FAULT_IRQ_PRESENT = 1'b1,
  parameter bit RECOMMENDED_LAYOUT = 1'b1,
  parameter int PA_WIDTH = 48,
  parameter bit ENABLE_CONFIGURABLE = 1'b1,
  parameter bit NS_WRITES_ALLOWED = 1'b0,
  parameter bit NS_CONFIGURABLE = 1'b1,
  parameter bit NS_RESET = 1'b1,
  parameter bit NS_FIXED = 1'b1,
  parameter bit SH_CONFIGURABLE = 1'b1,
  parameter logic [1:0] SH_FIXED = 2'h2,
  parameter bit MT_CONFIGURABLE = 1'b1,
  parameter logic [3:0] MT_FIXED = 4'h0
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault event from the error records
  input wire logic fault_event,
  // Message write to the interconnect
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [55:0] msg_addr,
  output logic [31:0] msg_data,
  output logic msg_ns,
  output logic [1:0] msg_sh,
  output logic [3:0] msg_mt,
  input wire logic msg_err,
  // Interrupt
  output logic irq
);
  localparam int AW = `FIM_ADDR_MSB + 1;

  fim_cfg_if #(.AW(AW)) cfg ();

  // Storage for the address field, payload and control fields.
  logic [AW-1:0] addr_reg;
  logic [31:0] payload_reg;
  logic enable_reg;
  logic ns_reg;
  logic [1:0] sh_reg;
  logic [3:0] mt_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [2:0] status_next;

  // Presence and layout decode.
  logic regs_present;
  logic impl_layout;
  assign regs_present = IRQ_CFG_PRESENT && (FAULT_IRQ_PRESENT || !RECOMMENDED_LAYOUT);
  assign impl_layout = !RECOMMENDED_LAYOUT;

  // Address decoding.
  logic wr_access;
  logic rd_access;
  logic sel_tlo;
  logic sel_thi;
  logic sel_pay;
  logic sel_ctl;
  logic sel_sts;
  logic sel_msk;
  logic mapped;
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign sel_tlo = (paddr == `FIM_OFS_TARGET_LO);
  assign sel_thi = (paddr == `FIM_OFS_TARGET_HI);
  assign sel_pay = (paddr == `FIM_OFS_PAYLOAD);
  assign sel_ctl = (paddr == `FIM_OFS_CONTROL);
  assign sel_sts = (paddr == `FIM_OFS_IRQ_STATUS);
  assign sel_msk = (paddr == `FIM_OFS_IRQ_MASK);
  assign mapped = sel_tlo || sel_thi || sel_pay || sel_ctl || sel_sts || sel_msk;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Byte-lane merge of write data onto the current register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Physical address mask: bits above the supported width and the low two bits stay zero.
  logic [AW-1:0] pa_mask;
  assign pa_mask = {{(AW-PA_WIDTH){1'b0}}, {(PA_WIDTH-`FIM_ADDR_LSB){1'b1}}, 2'b00};

  logic [63:0] addr_word;
  logic [31:0] ctl_word;
  logic [63:0] addr_new_lo;
  logic [63:0] addr_new_hi;
  assign addr_word = {8'h00, addr_reg & pa_mask};
  assign addr_new_lo = {addr_word[63:32], merge(addr_word[31:0], pwdata, pstrb)};
  assign addr_new_hi = {merge(addr_word[63:32], pwdata, pstrb), addr_word[31:0]};

  // Visible control fields, with fixed attributes reading as zero.
  logic en_vis;
  logic ns_vis;
  logic [1:0] sh_vis;
  logic [3:0] mt_vis;
  logic ns_cfg;
  assign ns_cfg = NS_CONFIGURABLE && !NS_WRITES_ALLOWED;
  assign en_vis = ENABLE_CONFIGURABLE ? enable_reg : 1'b0;
  assign ns_vis = ns_cfg ? ns_reg : 1'b0;
  assign sh_vis = SH_CONFIGURABLE ? sh_reg : 2'h0;
  assign mt_vis = MT_CONFIGURABLE ? mt_reg : 4'h0;
  assign ctl_word = {24'h000000, en_vis, ns_vis, sh_vis, mt_vis};

  logic [31:0] ctl_new;
  assign ctl_new = merge(ctl_word, pwdata, pstrb);

  // Read data selection; absent registers read as zero.
  logic [31:0] rd_mux;
  assign rd_mux = !regs_present ? 32'h0 :
                  sel_tlo ? addr_word[31:0] :
                  sel_thi ? addr_word[63:32] :
                  sel_pay ? payload_reg :
                  sel_ctl ? ctl_word :
                  sel_sts ? {29'h0, status_reg} :
                  sel_msk ? {29'h0, mask_reg} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  logic reg_wr;
  assign reg_wr = wr_access && regs_present;

  // Address and payload carry no reset, their contents are undefined until written.
  always_ff @(posedge pclk) begin
    if (reg_wr && sel_tlo) begin
      addr_reg <= addr_new_lo[AW-1:0] & pa_mask;
    end else if (reg_wr && sel_thi) begin
      addr_reg <= addr_new_hi[AW-1:0] & pa_mask;
    end
    if (reg_wr && sel_pay) begin
      payload_reg <= merge(payload_reg, pwdata, pstrb);
    end
    if (reg_wr && sel_ctl) begin
      sh_reg <= ctl_new[`FIM_CTL_SH_MSB:`FIM_CTL_SH_LSB];
      mt_reg <= ctl_new[`FIM_CTL_MT_MSB:`FIM_CTL_MT_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `FIM_CTL_ENABLE_RST;
      ns_reg <= NS_RESET;
    end else if (reg_wr && sel_ctl) begin
      enable_reg <= ctl_new[`FIM_CTL_ENABLE_BIT];
      ns_reg <= ctl_new[`FIM_CTL_NS_BIT];
    end
  end

  // Effective configuration delivered to the writer.
  assign cfg.enable = regs_present && !impl_layout && (ENABLE_CONFIGURABLE ? enable_reg : 1'b1);
  assign cfg.target = addr_reg & pa_mask;
  assign cfg.payload = payload_reg;
  assign cfg.attr.ns = NS_WRITES_ALLOWED ? 1'b1 : (ns_cfg ? ns_reg : NS_FIXED);
  assign cfg.attr.sh = SH_CONFIGURABLE ? sh_reg : SH_FIXED;
  assign cfg.attr.mt = MT_CONFIGURABLE ? mt_reg : MT_FIXED;

  logic sent_pulse;
  logic drop_pulse;
  logic err_pulse;

  fim_sender #(.AW(AW)) u_sender (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg),
    .fault_event(fault_event),
    .msg_valid(msg_valid),
    .msg_ready(msg_ready),
    .msg_addr(msg_addr),
    .msg_data(msg_data),
    .msg_ns(msg_ns),
    .msg_sh(msg_sh),
    .msg_mt(msg_mt),
    .msg_err(msg_err),
    .sent_pulse(sent_pulse),
    .drop_pulse(drop_pulse),
    .err_pulse(err_pulse)
  );

  // Sticky status: new events win over a write-one clear in the same cycle.
  logic [2:0] ev_vec;
  logic [2:0] clr_vec;
  assign ev_vec = {err_pulse, drop_pulse, sent_pulse};
  assign clr_vec = (wr_access && sel_sts && pstrb[0]) ? pwdata[2:0] : 3'h0;
  assign status_next = (status_reg & ~clr_vec) | ev_vec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 3'h0;
      mask_reg <= 3'h0;
    end else begin
      status_reg <= status_next;
      if (wr_access && sel_msk && pstrb[0]) begin
        mask_reg <= pwdata[2:0];
      end
    end
  end

  assign irq = |(status_reg & mask_reg);
endmodule
